// ### src/tta_pkg.sv
// Package: register map, reset values and state types of the temperature readout block
`default_nettype none
package tta_pkg;
  // Register pointers (command byte values)
  localparam logic [7:0] REG_LTEMP = 8'h00;
  localparam logic [7:0] REG_RTEMP = 8'h01;
  localparam logic [7:0] REG_STAT = 8'h02;
  localparam logic [7:0] REG_CFG = 8'h03;
  localparam logic [7:0] REG_LHI = 8'h05;
  localparam logic [7:0] REG_LLO = 8'h06;
  localparam logic [7:0] REG_RHI = 8'h07;
  localparam logic [7:0] REG_RLO = 8'h08;
  localparam logic [7:0] CMD_ONESHOT = 8'h0F;
  localparam logic [7:0] REG_RFRAC = 8'h10;
  localparam logic [7:0] REG_LFRAC = 8'h11;
  localparam logic [7:0] REG_ROT = 8'h19;
  localparam logic [7:0] REG_LOT = 8'h20;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // Field positions
  localparam int CFG_MASK = 7;
  localparam int CFG_STOP = 6;
  localparam int AF_LHI = 3;
  localparam int AF_LLO = 2;
  localparam int AF_RHI = 1;
  localparam int AF_RLO = 0;
  localparam int OF_LOC = 1;
  localparam int OF_REM = 0;
  localparam logic [4:0] FRAC_PAD = 5'h00;
  localparam logic [2:0] STAT_PAD = 3'h0;
  // Limit reset values
  localparam logic [7:0] LIM_0 = 8'h00;
  localparam logic [7:0] LIM_85 = 8'h55;
  localparam logic [7:0] LIM_95 = 8'h5F;
  localparam logic [7:0] LIM_125 = 8'h7D;
  localparam logic [7:0] HYST_DEF = 8'h0A;
  // Serial bit counter marks
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] CNT_REL = 4'h9;

  typedef enum logic [1:0] {SL_IDLE, SL_ADDR, SL_RX, SL_TX} tta_sl_state_t;
  typedef enum logic {CV_IDLE, CV_BUSY} tta_conv_t;

  typedef struct packed {
    logic [10:0] loc;
    logic [10:0] rem;
  } tta_reading_t;

  typedef struct packed {
    logic cmd_we;
    logic dat_we;
    logic [7:0] data;
  } tta_host_evt_t;

  typedef struct packed {
    logic scl_m, scl_s, scl_d;
    logic sda_m, sda_s, sda_d;
    tta_sl_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rd;
    logic first;
    logic oe;
    tta_host_evt_t evt;
  } tta_slave_t;

  typedef struct packed {
    logic [7:0] ptr, cfg;
    logic [7:0] lhi, llo, rhi, rlo, lot, rot;
    logic [7:0] ltemp, rtemp;
    logic [2:0] lfrac, rfrac;
    tta_conv_t conv;
    logic os_pend, os_run, start;
    logic [3:0] aflag;
    logic [1:0] oflag;
  } tta_main_t;
endpackage
`default_nettype wire

// ### src/tta_smbus_slave.sv
// Serial byte engine: start/stop detection, address match, byte receive and transmit
`default_nettype none
module tta_smbus_slave
  import tta_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h2A
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Register side
  input wire logic [7:0] rd_data_in,
  output tta_host_evt_t evt_out
);
  tta_slave_t r, n;
  logic rise, fall, start_c, stop_c;

  assign rise = r.scl_s & ~r.scl_d;
  assign fall = ~r.scl_s & r.scl_d;
  assign start_c = r.scl_s & r.scl_d & r.sda_d & ~r.sda_s;
  assign stop_c = r.scl_s & r.scl_d & ~r.sda_d & r.sda_s;

  always_comb begin
    n = r;
    n.scl_m = scl_in;
    n.scl_s = r.scl_m;
    n.scl_d = r.scl_s;
    n.sda_m = sda_in;
    n.sda_s = r.sda_m;
    n.sda_d = r.sda_s;
    n.evt.cmd_we = 1'b0;
    n.evt.dat_we = 1'b0;
    if (start_c) begin
      n.st = SL_ADDR;
      n.cnt = '0;
      n.oe = 1'b0;
    end else if (stop_c) begin
      n.st = SL_IDLE;
      n.oe = 1'b0;
    end else begin
      unique case (r.st)
        SL_IDLE: ;
        SL_ADDR, SL_RX: begin
          // Bytes arrive most significant bit first
          if (rise && r.cnt < BIT_ACK) begin
            n.sh = {r.sh[6:0], r.sda_s};
            n.cnt = r.cnt + 4'h1;
          end else if (fall && r.cnt == BIT_ACK) begin
            n.cnt = CNT_REL;
            if (r.st == SL_RX) begin
              n.oe = 1'b1;
              n.evt.cmd_we = r.first;
              n.evt.dat_we = ~r.first;
              n.evt.data = r.sh;
              n.first = 1'b0;
            end else if (r.sh[7:1] == SLAVE_ADDR) begin
              n.oe = 1'b1;
              n.rd = r.sh[0];
            end else begin
              n.st = SL_IDLE;
            end
          end else if (fall && r.cnt == CNT_REL) begin
            n.cnt = '0;
            if (r.st == SL_ADDR && r.rd) begin
              n.st = SL_TX;
              n.sh = rd_data_in;
              n.oe = ~rd_data_in[7];
            end else begin
              n.oe = 1'b0;
              if (r.st == SL_ADDR) begin
                n.st = SL_RX;
                n.first = 1'b1;
              end
            end
          end
        end
        SL_TX: begin
          if (fall && r.cnt < BIT_LAST) begin
            n.sh = {r.sh[6:0], 1'b0};
            n.oe = ~r.sh[6];
            n.cnt = r.cnt + 4'h1;
          end else if (fall && r.cnt == BIT_LAST) begin
            n.oe = 1'b0;
            n.cnt = BIT_ACK;
          end else if (rise && r.cnt == BIT_ACK) begin
            // Master NACK ends the read
            if (r.sda_s) n.st = SL_IDLE;
            else n.cnt = CNT_REL;
          end else if (fall && r.cnt == CNT_REL) begin
            n.sh = rd_data_in;
            n.oe = ~rd_data_in[7];
            n.cnt = '0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      r <= '0;
      // Pin samplers start at the idle-high bus level, so no false edge follows reset
      r.scl_m <= 1'b1;
      r.scl_s <= 1'b1;
      r.scl_d <= 1'b1;
      r.sda_m <= 1'b1;
      r.sda_s <= 1'b1;
      r.sda_d <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_out = r.oe;
  assign evt_out = r.evt;
endmodule
`default_nettype wire

// ### src/tta_readout.sv
// Temperature readout top: result registers, limits, conversion control and alarms
`default_nettype none
module tta_readout
  import tta_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h2A,
  parameter bit SAME_REMOTE_LIMITS = 1'b0,
  parameter logic [7:0] OVERTEMP_SHUTDOWN_N_HYST = HYST_DEF
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // Serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Converter
  output logic conv_start_out,
  input wire logic conv_done_in,
  input wire tta_reading_t reading_in,
  // Alarm pins
  output logic alert_n_out,
  output logic overtemp_shutdown_n_out
);
  localparam logic [7:0] RHI_RST = SAME_REMOTE_LIMITS ? LIM_85 : LIM_95;
  localparam logic [7:0] ROT_RST = SAME_REMOTE_LIMITS ? LIM_85 : LIM_125;

  tta_host_evt_t evt;
  tta_main_t r, n;
  logic [7:0] rd_byte;
  logic [7:0] lt_new, rt_new;
  logic done_ok;

  tta_smbus_slave #(.SLAVE_ADDR(SLAVE_ADDR)) u_slave (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_out(sda_oe_out),
    .rd_data_in(rd_byte),
    .evt_out(evt)
  );

  // Sets at the limit, releases below limit minus hysteresis, else holds
  function automatic logic overtemp_shutdown_n_next(input logic cur, input logic [7:0] t,
                                      input logic [7:0] lim, input logic [7:0] hy);
    logic [7:0] rel;
    rel = (lim > hy) ? lim - hy : BYTE_ZERO;
    if (t >= lim) return 1'b1;
    if (t < rel) return 1'b0;
    return cur;
  endfunction

  assign done_ok = conv_done_in && (r.conv == CV_BUSY);
  assign lt_new = reading_in.loc[10:3];
  assign rt_new = reading_in.rem[10:3];

  always_comb begin
    unique case (r.ptr)
      REG_LTEMP: rd_byte = r.ltemp;
      REG_RTEMP: rd_byte = r.rtemp;
      REG_STAT: rd_byte = {r.conv == CV_BUSY, r.aflag, STAT_PAD};
      REG_CFG: rd_byte = r.cfg;
      REG_LHI: rd_byte = r.lhi;
      REG_LLO: rd_byte = r.llo;
      REG_RHI: rd_byte = r.rhi;
      REG_RLO: rd_byte = r.rlo;
      REG_RFRAC: rd_byte = {r.rfrac, FRAC_PAD};
      REG_LFRAC: rd_byte = {r.lfrac, FRAC_PAD};
      REG_ROT: rd_byte = r.rot;
      REG_LOT: rd_byte = r.lot;
      default: rd_byte = BYTE_ZERO;
    endcase
  end

  always_comb begin
    n = r;
    n.start = 1'b0;
    unique case (r.conv)
      CV_IDLE: begin
        if (r.os_pend || !r.cfg[CFG_STOP]) begin
          n.conv = CV_BUSY;
          n.start = 1'b1;
          n.os_run = r.os_pend;
          n.os_pend = 1'b0;
        end
      end
      CV_BUSY: begin
        if (done_ok) begin
          // Integer and fraction latch together
          n.ltemp = lt_new;
          n.rtemp = rt_new;
          n.lfrac = reading_in.loc[2:0];
          n.rfrac = reading_in.rem[2:0];
          n.aflag[AF_LHI] = lt_new >= r.lhi;
          n.aflag[AF_RHI] = rt_new >= r.rhi;
          n.aflag[AF_LLO] = lt_new < r.llo;
          n.aflag[AF_RLO] = rt_new < r.rlo;
          n.oflag[OF_LOC] = overtemp_shutdown_n_next(r.oflag[OF_LOC], lt_new, r.lot, OVERTEMP_SHUTDOWN_N_HYST);
          n.oflag[OF_REM] = overtemp_shutdown_n_next(r.oflag[OF_REM], rt_new, r.rot, OVERTEMP_SHUTDOWN_N_HYST);
          n.conv = CV_IDLE;
          n.os_run = 1'b0;
        end else if (r.cfg[CFG_STOP] && !r.os_run) begin
          // Standby truncates a free-running conversion, old data kept
          n.conv = CV_IDLE;
        end
      end
    endcase
    if (evt.cmd_we) n.ptr = evt.data;
    // One-shot is ignored while a conversion is running
    if (evt.cmd_we && evt.data == CMD_ONESHOT && n.conv == CV_IDLE) n.os_pend = 1'b1;
    if (evt.dat_we) begin
      unique case (r.ptr)
        REG_CFG: n.cfg = evt.data;
        REG_LHI: n.lhi = evt.data;
        REG_LLO: n.llo = evt.data;
        REG_RHI: n.rhi = evt.data;
        REG_RLO: n.rlo = evt.data;
        REG_LOT: n.lot = evt.data;
        REG_ROT: n.rot = evt.data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      r <= '0;
      r.lhi <= LIM_85;
      r.rhi <= RHI_RST;
      r.llo <= LIM_0;
      r.rlo <= LIM_0;
      r.lot <= LIM_85;
      r.rot <= ROT_RST;
    end else begin
      r <= n;
    end
  end

  assign conv_start_out = r.start;
  assign alert_n_out = ~((|r.aflag) & ~r.cfg[CFG_MASK]);
  assign overtemp_shutdown_n_out = ~(|r.oflag);

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);

  sequence s_done;
    done_ok;
  endsequence
  sequence s_os_cmd;
    evt.cmd_we && evt.data == CMD_ONESHOT && r.conv == CV_IDLE && !r.os_pend;
  endsequence

  property p_frac_format;
    r.ptr == REG_RFRAC |-> rd_byte[7:5] == r.rfrac && rd_byte[4:0] == FRAC_PAD;
  endproperty
  a_frac_format: assert property (p_frac_format) else $error("fraction byte layout wrong");

  property p_standby;
    r.cfg[CFG_STOP] && r.conv == CV_IDLE && !r.os_pend |=> !conv_start_out;
  endproperty
  a_standby: assert property (p_standby) else $error("conversion started in standby");

  property p_oneshot;
    s_os_cmd |-> ##[1:3] conv_start_out;
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("one-shot did not start");

  // A standby write that lands with the start pulse truncates the run at once
  property p_busy;
    conv_start_out |-> r.conv == CV_BUSY ##1
      (r.conv == CV_BUSY || $past(conv_done_in) || $past(r.cfg[CFG_STOP] && !r.os_run));
  endproperty
  a_busy: assert property (p_busy) else $error("busy not shown during conversion");

  property p_limit_write;
    evt.dat_we && r.ptr == REG_RLO |=> r.rlo == $past(evt.data);
  endproperty
  a_limit_write: assert property (p_limit_write) else $error("low limit not written");

  property p_high_alarm;
    s_done ##0 (lt_new >= r.lhi) |=> r.aflag[AF_LHI] && (alert_n_out == r.cfg[CFG_MASK]);
  endproperty
  a_high_alarm: assert property (p_high_alarm) else $error("high alarm missed");

  property p_low_alarm;
    s_done ##0 (rt_new < r.rlo) |=> r.aflag[AF_RLO];
  endproperty
  a_low_alarm: assert property (p_low_alarm) else $error("low alarm missed");

  property p_limits_rst;
    $past(reset_in) |-> r.lhi == LIM_85 && r.rhi == RHI_RST && r.llo == LIM_0 && r.rlo == LIM_0;
  endproperty
  a_limits_rst: assert property (p_limits_rst) else $error("alarm limit reset value wrong");

  property p_overtemp_shutdown_n_rst;
    $past(reset_in) |-> r.lot == LIM_85 && r.rot == ROT_RST && overtemp_shutdown_n_out;
  endproperty
  a_overtemp_shutdown_n_rst: assert property (p_overtemp_shutdown_n_rst) else $error("overtemp limit reset wrong");

  property p_overtemp_shutdown_n_set;
    s_done ##0 (rt_new >= r.rot) |=> !overtemp_shutdown_n_out;
  endproperty
  a_overtemp_shutdown_n_set: assert property (p_overtemp_shutdown_n_set) else $error("overtemp not asserted");

  property p_overtemp_shutdown_n_hold;
    s_done ##0 (r.oflag[OF_LOC] && r.lot > OVERTEMP_SHUTDOWN_N_HYST && lt_new >= r.lot - OVERTEMP_SHUTDOWN_N_HYST)
      |=> r.oflag[OF_LOC];
  endproperty
  a_overtemp_shutdown_n_hold: assert property (p_overtemp_shutdown_n_hold) else $error("overtemp released early");

  property p_frac_latch;
    s_done |=> r.lfrac == $past(reading_in.loc[2:0]) && r.ltemp == $past(lt_new);
  endproperty
  a_frac_latch: assert property (p_frac_latch) else $error("result not latched");
endmodule
`default_nettype wire

// ### dv/tta_host_model.sv
// Bus host model: drives the bus clock and pulls the data line low through its enable
`default_nettype none
module tta_host_model
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A
) (
  // Bus pins
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_oe_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Clock idles high between frames
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end
  // Data changes in the low phase and is sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    sda_oe_out = ~b;
    #150;
    scl_out = 1'b1;
    #100;
    r = sda_in;
    #100;
    scl_out = 1'b0;
    #50;
  endtask
  // Waits out the device's acknowledge hold before raising the clock
  task automatic start_c;
    sda_oe_out = 1'b0;
    #300;
    scl_out = 1'b1;
    #100;
    sda_oe_out = 1'b1;
    #100;
    scl_out = 1'b0;
    #50;
  endtask
  task automatic stop_c;
    sda_oe_out = 1'b1;
    #300;
    scl_out = 1'b1;
    #100;
    sda_oe_out = 1'b0;
    #200;
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, ack);
  endtask
  task automatic recv(output logic [7:0] d, output logic nak);
    logic r;
    start_c();
    put_byte({DEV_ADDR, 1'b1}, nak);
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(1'b1, r);
    stop_c();
  endtask
  task automatic write_reg(input logic [7:0] cmd, d, input logic data, output logic nak);
    logic a0, a1, a2;
    start_c();
    put_byte({DEV_ADDR, 1'b0}, a0);
    put_byte(cmd, a1);
    a2 = 1'b0;
    if (data) put_byte(d, a2);
    stop_c();
    nak = a0 | a1 | a2;
  endtask
  task automatic read_reg(input logic [7:0] cmd, output logic [7:0] d, output logic nak);
    logic a0, a1, a2;
    start_c();
    put_byte({DEV_ADDR, 1'b0}, a0);
    put_byte(cmd, a1);
    recv(d, a2);
    nak = a0 | a1 | a2;
  endtask
endmodule
`default_nettype wire

// ### dv/tta_readout_tb.sv
// Testbench for the temperature readout block
`default_nettype none
module tta_readout_tb
  import tta_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] RST_TAB [6] = '{{REG_LHI, LIM_85}, {REG_LLO, LIM_0},
    {REG_RHI, LIM_95}, {REG_RLO, LIM_0}, {REG_LOT, LIM_85}, {REG_ROT, LIM_125}};
  // Local and remote integer, then expected alert_n and overtemp_n
  localparam logic [17:0] ALM_TAB [11] = '{{8'h32, 8'h32, 2'b11}, {8'h32, 8'h5F, 2'b01},
    {8'h32, 8'h7D, 2'b00}, {8'h32, 8'h74, 2'b00}, {8'h32, 8'h72, 2'b01}, {8'h55, 8'h32, 2'b00},
    {8'h4B, 8'h32, 2'b10}, {8'h4A, 8'h32, 2'b11}, {8'h13, 8'h32, 2'b01}, {8'h14, 8'h32, 2'b11},
    {8'h14, 8'h13, 2'b01}};
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic conv_done = 1'b0;
  logic scl, host_oe, sda_oe, sda_val, sda_wire, conv_start, alert_n, overtemp_shutdown_n_n;
  tta_reading_t reading = '0;
  tta_reading_t next_rd = '0;
  int mismatches = 0;
  int tests_run = 0;
  int lat = 0;
  int starts = 0;
  // Open-drain data line with pull-up: a released line reads high
  assign sda_wire = (sda_oe ? sda_val : 1'b1) & ~host_oe;
  always #25 sys_clk_in = ~sys_clk_in;
  tta_readout dut_u (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .scl_in(scl),
    .sda_in(sda_wire), .sda_out(sda_val), .sda_oe_out(sda_oe), .conv_start_out(conv_start),
    .conv_done_in(conv_done), .reading_in(reading), .alert_n_out(alert_n),
    .overtemp_shutdown_n_out(overtemp_shutdown_n_n));
  tta_host_model host_u (.sda_in(sda_wire), .scl_out(scl), .sda_oe_out(host_oe));
  // Converter: answers each start after a fixed latency
  always @(posedge sys_clk_in) begin
    #2;
    conv_done = 1'b0;
    if (conv_start) begin
      lat = 12;
      starts++;
    end else if (lat > 0) begin
      lat--;
      if (lat == 0) begin
        conv_done = 1'b1;
        reading = next_rd;
      end
    end
  end
  task automatic check(input string what, input logic [7:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd_chk(input logic [7:0] cmd, exp);
    logic [7:0] d;
    logic nak;
    host_u.read_reg(cmd, d, nak);
    check($sformatf("reg %h", cmd), d, exp);
    check("read ack", {7'h00, nak}, 8'h00);
  endtask
  task automatic convert(input logic [7:0] lt, rt, input logic [2:0] lf, rf);
    logic [7:0] s;
    logic nak;
    next_rd = {lt, lf, rt, rf};
    host_u.write_reg(CMD_ONESHOT, BYTE_ZERO, 1'b0, nak);
    s = 8'h80;
    for (int i = 0; i < 4 && s[7] !== 1'b0; i++) host_u.read_reg(REG_STAT, s, nak);
    check("busy", s & 8'h80, 8'h00);
  endtask
  task automatic done(input string n);
    $display("test %s finished", n);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #3_000_000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    logic [7:0] d;
    logic nak;
    int s0;
    repeat (6) @(posedge sys_clk_in);
    #2;
    reset_in = 1'b0;
    repeat (2) @(posedge sys_clk_in);
    // Keep all bus edges off the sampling edge of the system clock
    #2;
    s0 = starts;
    foreach (RST_TAB[i]) rd_chk(RST_TAB[i][15:8], RST_TAB[i][7:0]);
    rd_chk(8'h04, BYTE_ZERO);
    check("free run", {7'h00, starts > s0}, 8'h01);
    done("reset values");
    host_u.write_reg(REG_CFG, 8'h40, 1'b1, nak);
    s0 = starts;
    rd_chk(REG_CFG, 8'h40);
    check("standby", {7'h00, starts > s0}, 8'h00);
    host_u.write_reg(REG_LLO, 8'h14, 1'b1, nak);
    host_u.write_reg(REG_RLO, 8'h14, 1'b1, nak);
    rd_chk(REG_RLO, 8'h14);
    done("standby");
    foreach (ALM_TAB[i]) begin
      convert(ALM_TAB[i][17:10], ALM_TAB[i][9:2], i[2:0], ~i[2:0]);
      check("alert_n", {7'h00, alert_n}, {7'h00, ALM_TAB[i][1]});
      check("overtemp_n", {7'h00, overtemp_shutdown_n_n}, {7'h00, ALM_TAB[i][0]});
      rd_chk(REG_LTEMP, ALM_TAB[i][17:10]);
      rd_chk(REG_LFRAC, {i[2:0], FRAC_PAD});
      rd_chk(REG_RTEMP, ALM_TAB[i][9:2]);
      rd_chk(REG_RFRAC, {~i[2:0], FRAC_PAD});
    end
    // Mask bit forces the pin inactive while the remote low alarm still stands
    host_u.write_reg(REG_CFG, 8'hC0, 1'b1, nak);
    check("alert masked", {7'h00, alert_n}, 8'h01);
    done("alarms");
    host_u.write_reg(REG_LFRAC, 8'hFF, 1'b1, nak);
    rd_chk(REG_LFRAC, 8'h40);
    host_u.recv(d, nak);
    check("receive", d, 8'h40);
    host_u.start_c();
    host_u.put_byte(8'hAA, nak);
    host_u.stop_c();
    check("wrong address", {7'h00, nak}, 8'h01);
    check("sda value", {7'h00, sda_val}, 8'h00);
    done("access");
    report_and_stop();
  end
endmodule
`default_nettype wire
